// ==== rtl/tas_device_end.sv ====
// Converter end: control byte receiver, conversion sequencer,
// result shifter, panel driver and touch interrupt control.
// Assumes the host makes the serial clock and select; all link inputs
// are sampled by clk_i.
// Overview of operation
// - Take input on rising, update output falling
// - Drive output and busy only while selected
// - Raise busy on falling edge starting conversion
// - Overlapped next byte allows 15-clock conversions
// - Result straight binary, most significant first
// - Eight-bit mode ends four clocks sooner
// - Power bit one keeps converter powered
// - Single-ended: panel drivers on acquisition only
// - Differential: drivers on acquisition and conversion
// - Deselect powers down, abandons conversion
// - Deselect leaves reference power unchanged
// - Power-down: Y minus on, touch drives interrupt
// - Position measurement disconnects X plus pull-up
// - Position measurement holds interrupt low
// - Other measurements hold interrupt high
// - Power bit one disables touch detection
// - Touch detection returns at end of conversion
// - Host masks interrupt while sending bytes
// - Start bit begins eight-bit control byte
// - Mode bit low twelve, high eight bits
// - Reference bit high single-ended, low differential
// - Power field decoded into four modes
`timescale 1ns/100ps
`default_nettype none
`include "tas_consts.svh"
module tas_device_end import tas_pkg::*; #(
   parameter int RES_W = 12
) (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   tas_link_if.dev link,
   input wire logic [RES_W-1:0] sample_value_i,
   input wire logic touch_sense_i,
   output logic [2:0] channel_o,
   output logic panel_drive_o,
   output logic y_minus_drive_o,
   output logic xp_pullup_en_o,
   output logic adc_powered_o,
   output logic ref_powered_o
);
   if (RES_W < 8 || RES_W > 15) begin : g_chk
      $error("RES_W must lie between 8 and 15");
   end
   logic [3:0] sync_w;
   logic sclk_s;
   logic cs_n_s;
   logic din_s;
   logic touch_s;
   logic sclk_d_reg;
   logic sclk_rise;
   logic sclk_fall;
   logic selected;
   tas_sync2 #(.WIDTH(4), .RST_VAL(4'h5)) u_sync (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .d_i({link.sclk, link.cs_n, link.din, touch_sense_i}),
      .q_o(sync_w)
   );
   assign {sclk_s, cs_n_s, din_s, touch_s} = sync_w;
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         sclk_d_reg <= 1'h0;
      end else begin
         sclk_d_reg <= sclk_s;
      end
   end
   assign selected = ~cs_n_s;
   assign sclk_rise = selected & sclk_s & ~sclk_d_reg;
   assign sclk_fall = selected & ~sclk_s & sclk_d_reg;

   // Control byte receiver
   tas_phase_t phase_reg;
   logic rx_active_reg;
   logic [2:0] rx_cnt_reg;
   logic [5:0] rx_sr_reg;
   logic [2:0] rx_ch_reg;
   logic [7:0] ctrl_reg;
   logic rx_accept;
   logic byte_done;

   // New byte may overlap the result of the previous one
   assign rx_accept = (phase_reg == PH_IDLE) || (phase_reg == PH_DATA);
   assign byte_done = sclk_rise & rx_active_reg &
                      (rx_cnt_reg == `TAS_RX_LAST);

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         rx_active_reg <= 1'h0;
         rx_cnt_reg <= 3'h0;
         rx_sr_reg <= 6'h00;
         rx_ch_reg <= 3'h0;
      end else if (!selected) begin
         rx_active_reg <= 1'h0;
         rx_cnt_reg <= 3'h0;
      end else if (sclk_rise) begin
         if (!rx_active_reg) begin
            // Low bits before the start bit are ignored
            rx_active_reg <= rx_accept & din_s;
            rx_cnt_reg <= 3'h0;
         end else begin
            rx_sr_reg <= {rx_sr_reg[4:0], din_s};
            rx_cnt_reg <= rx_cnt_reg + 3'h1;
            if (rx_cnt_reg == `TAS_RX_CH_DONE) begin
               rx_ch_reg <= {rx_sr_reg[1:0], din_s};
            end
            if (byte_done) begin
               rx_active_reg <= 1'h0;
            end
         end
      end
   end

   // Last complete control byte; not cleared by deselect
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         ctrl_reg <= `TAS_CTRL_RST;
      end else if (byte_done) begin
         ctrl_reg <= {1'h1, rx_sr_reg, din_s};
      end
   end

   // Conversion sequencer and result shifter
   logic busy_reg;
   logic dout_reg;
   logic [3:0] bit_cnt_reg;
   logic [RES_W-1:0] res_reg;
   logic [2:0] conv_ch_reg;
   logic conv_ser_reg;
   logic conv_on_reg;
   logic ref_on_reg;
   logic eoc;
   logic [3:0] nbits;

   // Mode bit high selects the short conversion
   assign nbits = ctrl_reg[`TAS_CB_MODE] ? `TAS_NBITS_8 : 4'(RES_W);
   // End of conversion: falling edge after bit 1 went out
   assign eoc = sclk_fall & (phase_reg == PH_DATA) & (bit_cnt_reg == 4'h1);

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         phase_reg <= PH_IDLE;
         busy_reg <= 1'h0;
         dout_reg <= 1'h0;
         bit_cnt_reg <= 4'h0;
         res_reg <= '0;
         conv_ch_reg <= 3'h0;
         conv_ser_reg <= 1'h0;
      end else if (!selected) begin
         // Abandon conversion at once
         phase_reg <= PH_IDLE;
         busy_reg <= 1'h0;
         dout_reg <= 1'h0;
      end else if (byte_done) begin
         phase_reg <= PH_ACQ;
         conv_ch_reg <= rx_ch_reg;
         conv_ser_reg <= rx_sr_reg[1];
      end else if (sclk_fall) begin
         case (phase_reg)
            PH_ACQ: begin
               busy_reg <= 1'h1;
               res_reg <= sample_value_i;
               bit_cnt_reg <= nbits - 4'h1;
               phase_reg <= PH_BUSY;
            end
            PH_BUSY: begin
               busy_reg <= 1'h0;
               dout_reg <= res_reg[RES_W-1];
               res_reg <= {res_reg[RES_W-2:0], 1'h0};
               phase_reg <= PH_DATA;
            end
            PH_DATA: begin
               if (bit_cnt_reg == 4'h0) begin
                  dout_reg <= 1'h0;
                  phase_reg <= PH_IDLE;
               end else begin
                  dout_reg <= res_reg[RES_W-1];
                  res_reg <= {res_reg[RES_W-2:0], 1'h0};
                  bit_cnt_reg <= bit_cnt_reg - 4'h1;
               end
            end
            default: begin
               dout_reg <= 1'h0;
            end
         endcase
      end
   end

   // Conversion activity and reference power latch
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         conv_on_reg <= 1'h0;
         ref_on_reg <= 1'h0;
      end else if (!selected) begin
         conv_on_reg <= 1'h0;
      end else if (sclk_fall && phase_reg == PH_ACQ) begin
         conv_on_reg <= 1'h1;
         ref_on_reg <= ctrl_reg[`TAS_CB_PD1];
      end else if (eoc) begin
         conv_on_reg <= 1'h0;
      end
   end

   // Touch detection enable
   logic pen_en_reg;
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         pen_en_reg <= 1'h1;
      end else if (byte_done && din_s) begin
         pen_en_reg <= 1'h0;
      end else if (eoc && !ctrl_reg[`TAS_CB_PD0]) begin
         pen_en_reg <= 1'h1;
      end
   end

   // Panel, interrupt and power outputs
   logic acq;
   logic measuring;
   logic [2:0] act_ch;
   logic pos_ch;
   logic pen_path;
   logic [7:0] pos_mask;

   assign pos_mask = `TAS_POS_CH_MASK;
   assign acq = (rx_active_reg & (rx_cnt_reg >= `TAS_RX_ACQ_FROM)) |
                (phase_reg == PH_ACQ);
   assign measuring = selected & (acq | conv_on_reg);
   assign act_ch = acq ? rx_ch_reg : conv_ch_reg;
   assign pos_ch = pos_mask[act_ch];
   assign pen_path = ~measuring & pen_en_reg & ~ctrl_reg[`TAS_CB_PD0];
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         link.dout <= 1'h0;
         link.busy <= 1'h0;
         link.dout_oe <= 1'h0;
         link.busy_oe <= 1'h0;
         link.touch_irq_n <= 1'h1;
         channel_o <= 3'h0;
         panel_drive_o <= 1'h0;
         y_minus_drive_o <= 1'h0;
         xp_pullup_en_o <= 1'h1;
         adc_powered_o <= 1'h0;
         ref_powered_o <= 1'h0;
      end else begin
         link.dout <= dout_reg;
         link.busy <= busy_reg;
         link.dout_oe <= selected;
         link.busy_oe <= selected;
         if (measuring) begin
            link.touch_irq_n <= ~pos_ch;
         end else if (pen_path) begin
            link.touch_irq_n <= touch_s;
         end else begin
            link.touch_irq_n <= 1'h1;
         end
         channel_o <= act_ch;
         // Drivers follow the reference mode
         panel_drive_o <= measuring & pos_ch & (acq | ~conv_ser_reg);
         y_minus_drive_o <= pen_path;
         xp_pullup_en_o <= ~(measuring & pos_ch);
         // Full power or power-down between conversions
         adc_powered_o <= selected & (measuring | ctrl_reg[`TAS_CB_PD0]);
         ref_powered_o <= ref_on_reg;
      end
   end
endmodule : tas_device_end
`default_nettype wire

// ==== rtl/tas_consts.svh ====
// Constants of the touch converter serial link: control byte fields,
// channel classes, host timing and host register map.
// Assumes inclusion by bare name from the modules and the bench.
`ifndef TAS_CONSTS_SVH
`define TAS_CONSTS_SVH
// Control byte field positions
`define TAS_CB_START 7
`define TAS_CB_CH_HI 6
`define TAS_CB_CH_LO 4
`define TAS_CB_MODE 3
`define TAS_CB_SER 2
`define TAS_CB_PD1 1
`define TAS_CB_PD0 0
`define TAS_CTRL_RST 8'h00
// Receiver bit counts after the start bit
`define TAS_RX_CH_DONE 3'h2
`define TAS_RX_ACQ_FROM 3'h3
`define TAS_RX_LAST 3'h6
// Channels that measure position or pressure (one bit per channel code)
`define TAS_POS_CH_MASK 8'h3A
`define TAS_NBITS_8 4'h8
// Host timing
`define TAS_CLK_PERIOD_NS 100
`define TAS_SCLK_PERIOD_NS 800
`define TAS_SCLK_HALF ((`TAS_SCLK_PERIOD_NS) / (2 * `TAS_CLK_PERIOD_NS))
`define TAS_XFER_LAST 5'h17
`define TAS_CAP_FIRST 5'h09
// Host registers
`define TAS_REG_CMD 4'h0
`define TAS_REG_STATUS 4'h4
`define TAS_REG_RESULT 4'h8
`define TAS_ST_ACTIVE 0
`define TAS_ST_DONE 1
`define TAS_ST_TOUCH 2
`endif

// ==== rtl/tas_pkg.sv ====
// Types shared by both ends of the touch converter serial link.
// Assumes nothing beyond the constants header.
package tas_pkg;
   typedef enum logic [1:0] {
      PH_IDLE = 2'h0,
      PH_ACQ = 2'h1,
      PH_BUSY = 2'h2,
      PH_DATA = 2'h3
   } tas_phase_t;
   typedef enum logic [2:0] {
      HS_IDLE = 3'h0,
      HS_LEAD = 3'h1,
      HS_LOW = 3'h2,
      HS_HIGH = 3'h3,
      HS_TAIL = 3'h4
   } tas_hstate_t;
endpackage : tas_pkg

// ==== rtl/tas_link_if.sv ====
// Serial link between the touch converter and its host.
// Assumes the bench resolves the two-way wires from the enables.
`timescale 1ns/100ps
`default_nettype none
interface tas_link_if;
   logic cs_n;
   logic sclk;
   logic din;
   logic dout;
   logic dout_oe;
   logic busy;
   logic busy_oe;
   logic touch_irq_n;
   modport dev (
      input cs_n, sclk, din,
      output dout, dout_oe, busy, busy_oe, touch_irq_n
   );
   modport host (
      output cs_n, sclk, din,
      input dout, dout_oe, busy, busy_oe, touch_irq_n
   );
endinterface : tas_link_if
`default_nettype wire

// ==== rtl/tas_sync2.sv ====
// Two flip-flop synchroniser for levels from another clock domain.
// Assumes single-bit levels; no bus coherence across bits.
`timescale 1ns/100ps
`default_nettype none
module tas_sync2 #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic [WIDTH-1:0] d_i,
   output logic [WIDTH-1:0] q_o
);
   logic [WIDTH-1:0] meta_reg;
   logic [WIDTH-1:0] sync_reg;

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         meta_reg <= RST_VAL;
         sync_reg <= RST_VAL;
      end else begin
         meta_reg <= d_i;
         sync_reg <= meta_reg;
      end
   end

   assign q_o = sync_reg;
endmodule : tas_sync2
`default_nettype wire

// ==== rtl/tas_host_end.sv ====
// Host end: register port for software, serial clock divider and one
// 24-clock transfer per command, with touch events masked meanwhile.
// Assumes software writes the control byte and polls status.
`timescale 1ns/100ps
`default_nettype none
`include "tas_consts.svh"
module tas_host_end import tas_pkg::*; #(
   parameter int HALF_DIV = `TAS_SCLK_HALF,
   parameter int RES_W = 12
) (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   tas_link_if.host link,
   input wire logic [3:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_we_i,
   input wire logic reg_re_i,
   output logic [31:0] reg_rdata_o
);
   if (HALF_DIV < 2 || HALF_DIV > 255 || RES_W < 8 || RES_W > 15) begin : g_chk
      $error("HALF_DIV or RES_W out of range");
   end

   logic [2:0] sync_w;
   logic dout_s;
   logic busy_s;
   logic irq_n_s;

   tas_sync2 #(.WIDTH(3), .RST_VAL(3'h1)) u_sync (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .d_i({link.dout, link.busy, link.touch_irq_n}),
      .q_o(sync_w)
   );
   assign {dout_s, busy_s, irq_n_s} = sync_w;

   tas_hstate_t state_reg;
   logic [7:0] div_reg;
   logic [4:0] idx_reg;
   logic [7:0] tx_reg;
   logic [RES_W-1:0] rx_reg;
   logic [RES_W-1:0] result_reg;
   logic mode8_reg;
   logic done_reg;
   logic touch_reg;
   logic half_end;
   logic start;
   logic finish;
   logic st_read;

   assign half_end = (div_reg == 8'(HALF_DIV - 1));
   assign start = reg_we_i && reg_addr_i == `TAS_REG_CMD &&
                  state_reg == HS_IDLE;
   assign finish = (state_reg == HS_TAIL) && half_end;
   assign st_read = reg_re_i && reg_addr_i == `TAS_REG_STATUS;

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         state_reg <= HS_IDLE;
         div_reg <= 8'h00;
         idx_reg <= 5'h00;
         tx_reg <= 8'h00;
         rx_reg <= '0;
         mode8_reg <= 1'h0;
         link.cs_n <= 1'h1;
         link.sclk <= 1'h0;
         link.din <= 1'h0;
      end else begin
         div_reg <= (state_reg == HS_IDLE || half_end) ? 8'h00 :
                    div_reg + 8'h01;
         case (state_reg)
            HS_IDLE: begin
               if (start) begin
                  tx_reg <= reg_wdata_i[7:0];
                  mode8_reg <= reg_wdata_i[`TAS_CB_MODE];
                  link.cs_n <= 1'h0;
                  idx_reg <= 5'h00;
                  state_reg <= HS_LEAD;
               end
            end
            HS_LEAD, HS_LOW: begin
               if (half_end && state_reg == HS_LEAD) begin
                  link.din <= tx_reg[7];
                  tx_reg <= {tx_reg[6:0], 1'h0};
                  state_reg <= HS_LOW;
               end else if (half_end) begin
                  link.sclk <= 1'h1;
                  state_reg <= HS_HIGH;
               end
            end
            HS_HIGH: begin
               if (half_end) begin
                  // Sample late in the high half, past the sync delay
                  if (idx_reg >= `TAS_CAP_FIRST &&
                      idx_reg < `TAS_CAP_FIRST + 5'(RES_W)) begin
                     rx_reg <= {rx_reg[RES_W-2:0], dout_s};
                  end
                  link.sclk <= 1'h0;
                  idx_reg <= idx_reg + 5'h01;
                  if (idx_reg == `TAS_XFER_LAST) begin
                     link.din <= 1'h0;
                     state_reg <= HS_TAIL;
                  end else begin
                     link.din <= tx_reg[7];
                     tx_reg <= {tx_reg[6:0], 1'h0};
                     state_reg <= HS_LOW;
                  end
               end
            end
            HS_TAIL: begin
               if (half_end) begin
                  link.cs_n <= 1'h1;
                  state_reg <= HS_IDLE;
               end
            end
            default: begin
               state_reg <= HS_IDLE;
            end
         endcase
      end
   end

   // Result capture and sticky flags; a new event beats the read clear
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         result_reg <= '0;
         done_reg <= 1'h0;
         touch_reg <= 1'h0;
      end else begin
         if (finish) begin
            result_reg <= mode8_reg ? (rx_reg >> (RES_W - 8)) : rx_reg;
         end
         done_reg <= finish | (done_reg & ~st_read);
         // Touch seen only while no byte is being sent
         touch_reg <= (~irq_n_s & link.cs_n & state_reg == HS_IDLE) |
                      (touch_reg & ~st_read);
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         reg_rdata_o <= 32'h0000_0000;
      end else if (reg_re_i) begin
         case (reg_addr_i)
            `TAS_REG_STATUS: begin
               reg_rdata_o <= {29'h0, touch_reg, done_reg,
                               state_reg != HS_IDLE};
            end
            `TAS_REG_RESULT: begin
               reg_rdata_o <= {{(32 - RES_W){1'h0}}, result_reg};
            end
            default: begin
               reg_rdata_o <= 32'h0000_0000;
            end
         endcase
      end else begin
         reg_rdata_o <= 32'h0000_0000;
      end
   end
endmodule : tas_host_end
`default_nettype wire

// ==== tb/tas_link_props.sv ====
// Checker on the serial link between converter end and host end.
// Assumes instantiation in the bench beside the link interface.
`timescale 1ns/100ps
`default_nettype none
module tas_link_props (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic dout,
   input wire logic dout_oe,
   input wire logic busy,
   input wire logic busy_oe
);
   default clocking dflt @(posedge clk_i);
   endclocking
   default disable iff (sys_rst_i);

   sequence s_desel;
      cs_n [*6];
   endsequence
   sequence s_sel;
      (!cs_n) [*6];
   endsequence
   // One serial clock period high, then low
   sequence s_busy_pulse;
      busy [*7] ##[1:2] !busy;
   endsequence

   a_oe_off_desel: assert property (s_desel |-> !dout_oe && !busy_oe)
      else $error("Outputs enabled while deselected");
   a_oe_on_sel: assert property (s_sel |-> dout_oe && busy_oe)
      else $error("Outputs not enabled while selected");
   a_desel_quiet: assert property (s_desel |-> !dout && !busy)
      else $error("Data or busy active while deselected");
   a_abort_fast: assert property (
      $rose(cs_n) |-> ##[1:5] (!dout_oe && !busy && !dout))
      else $error("Deselect did not stop the conversion");
   a_busy_on_fall: assert property ($rose(busy) |-> !$past(sclk, 2))
      else $error("Busy rose outside a serial clock low phase");
   a_busy_width: assert property ($rose(busy) |-> s_busy_pulse)
      else $error("Busy pulse length wrong");
   a_dout_on_fall: assert property (
      $changed(dout) && dout_oe |-> !$past(sclk, 2))
      else $error("Data changed outside a serial clock low phase");
   a_busy_dout_zero: assert property (busy |-> !dout)
      else $error("Data not zero during busy");
endmodule : tas_link_props
`default_nettype wire

// ==== tb/tb.sv ====
// Bench for both link ends: software port in, converter side modelled.
// Assumes the design files are compiled first; the run ends in end_sim.
`timescale 1ns/100ps
`default_nettype none
`include "tas_consts.svh"
module tb;
   logic clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic [3:0] reg_addr_i = 4'h0;
   logic [31:0] reg_wdata_i = 32'h0;
   logic reg_we_i = 1'b0;
   logic reg_re_i = 1'b0;
   logic [31:0] reg_rdata_o;
   logic [11:0] sample_value_i = 12'h000;
   logic touch_sense_i = 1'b1;
   logic panel_drive_o, y_minus_drive_o, xp_pullup_en_o;
   logic adc_powered_o, ref_powered_o;
   logic [7:0] pmask = `TAS_POS_CH_MASK;
   int fail_count = 0;
   int num_checks = 0;
   int fcnt = 0;
   logic sclk_q = 1'b0;
   logic [23:0] wire_bits = 24'h0;
   logic [23:0] busy_bits = 24'h0;
   logic pan7, pan9, xp9, irq9, irq23, adc23;
   logic [2:0] channel_o, ch9;
   logic [31:0] rd;

   always #50 clk_i = ~clk_i;

   tas_link_if link ();
   tas_host_end u_tas_host_end (
      .clk_i(clk_i), .sys_rst_i(sys_rst_i), .link(link),
      .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
      .reg_we_i(reg_we_i), .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o)
   );
   tas_device_end u_tas_device_end (
      .clk_i(clk_i), .sys_rst_i(sys_rst_i), .link(link),
      .sample_value_i(sample_value_i), .touch_sense_i(touch_sense_i),
      .channel_o(channel_o), .panel_drive_o(panel_drive_o),
      .y_minus_drive_o(y_minus_drive_o), .xp_pullup_en_o(xp_pullup_en_o),
      .adc_powered_o(adc_powered_o), .ref_powered_o(ref_powered_o)
   );
   tas_link_props u_tas_link_props (
      .clk_i(clk_i), .sys_rst_i(sys_rst_i), .cs_n(link.cs_n),
      .sclk(link.sclk), .dout(link.dout), .dout_oe(link.dout_oe),
      .busy(link.busy), .busy_oe(link.busy_oe)
   );

   // Wire capture at each serial clock fall inside a frame
   always @(negedge clk_i) begin
      if (link.cs_n) begin
         fcnt = 0;
      end else if (sclk_q && !link.sclk) begin
         fcnt = fcnt + 1;
         wire_bits = {wire_bits[22:0], link.dout};
         busy_bits = {busy_bits[22:0], link.busy};
         if (fcnt == 7) pan7 = panel_drive_o;
         if (fcnt == 9) begin
            pan9 = panel_drive_o;
            ch9 = channel_o;
            xp9 = xp_pullup_en_o;
            irq9 = link.touch_irq_n;
         end
         if (fcnt == 23) begin
            irq23 = link.touch_irq_n;
            adc23 = adc_powered_o;
         end
      end
      sclk_q = link.sclk;
   end

   task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("Error at %0t: value %h, expected %h", $time, got, exp);
      end
   endtask : chk_val

   task automatic chk_bit(input logic got, input logic exp);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("Error at %0t: flag %b, expected %b", $time, got, exp);
      end
   endtask : chk_bit

   task automatic end_sim();
      $display("checks %0d, mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : end_sim

   task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_we_i <= 1'b1;
      @(posedge clk_i);
      reg_we_i <= 1'b0;
   endtask : reg_write

   task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
      @(posedge clk_i);
      reg_addr_i <= a;
      reg_re_i <= 1'b1;
      @(posedge clk_i);
      reg_re_i <= 1'b0;
      @(negedge clk_i);
      d = reg_rdata_o;
   endtask : reg_read

   task automatic touch(input logic t, input int n);
      @(posedge clk_i);
      touch_sense_i <= t;
      repeat (n) @(negedge clk_i);
   endtask : touch

   task automatic wait_done();
      int n;
      n = 0;
      rd = 32'h0;
      while (rd[`TAS_ST_DONE] !== 1'b1 && n < 300) begin
         reg_read(`TAS_REG_STATUS, rd);
         n++;
      end
      if (rd[`TAS_ST_DONE] !== 1'b1) begin
         fail_count++;
         $display("Error at %0t: transfer never completed", $time);
         end_sim();
      end
   endtask : wait_done

   // One full transfer, then result, wire bits and busy slot compared
   task automatic run_conv(input logic [7:0] cb, input logic [11:0] smp);
      logic [11:0] res;
      logic [23:0] exp_w;
      @(posedge clk_i);
      sample_value_i <= smp;
      reg_write(`TAS_REG_CMD, {24'h0, cb});
      wait_done();
      res = cb[`TAS_CB_MODE] ? {4'h0, smp[11:4]} : smp;
      exp_w = cb[`TAS_CB_MODE] ? {9'h000, smp[11:4], 7'h00}
                               : {9'h000, smp, 3'h0};
      reg_read(`TAS_REG_RESULT, rd);
      chk_val(rd, {20'h0, res});
      chk_val({8'h0, wire_bits}, {8'h0, exp_w});
      chk_val({8'h0, busy_bits}, 32'h0000_8000);
   endtask : run_conv

   initial begin
      logic pos;
      logic ser;
      logic [7:0] cb;
      logic [11:0] smp;
      repeat (10) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      touch(1'b0, 10);
      chk_bit(link.touch_irq_n, 1'b0);
      chk_bit(y_minus_drive_o, 1'b1);
      reg_read(`TAS_REG_STATUS, rd);
      chk_bit(rd[`TAS_ST_TOUCH], 1'b1);
      reg_read(4'hC, rd);
      chk_val(rd, 32'h0);
      touch(1'b1, 10);
      chk_bit(link.touch_irq_n, 1'b1);
      $display("test idle_touch done");
      for (int ch = 0; ch < 8; ch++) begin
         pos = pmask[ch];
         ser = ch[1];
         cb = {1'b1, ch[2:0], 1'b0, ser, 2'b00};
         smp = 12'h249 * ch[2:0];
         touch(pos, 4);
         run_conv(cb, smp);
         chk_bit(irq9, ~pos);
         chk_val({29'h0, ch9}, {29'h0, cb[6:4]});
         chk_bit(pan7, pos);
         chk_bit(pan9, pos & ~ser);
         chk_bit(xp9, ~pos);
         $display("test channel %0d done", ch);
      end
      touch(1'b0, 4);
      run_conv(8'h9D, 12'hC3A);
      chk_bit(irq23, 1'b1);
      chk_bit(adc23, 1'b1);
      touch(1'b0, 10);
      chk_bit(link.touch_irq_n, 1'b1);
      chk_bit(y_minus_drive_o, 1'b0);
      chk_bit(ref_powered_o, 1'b0);
      $display("test short_full_power done");
      run_conv(8'h92, 12'h801);
      chk_bit(irq23, 1'b0);
      chk_bit(adc23, 1'b0);
      touch(1'b0, 10);
      chk_bit(ref_powered_o, 1'b1);
      chk_bit(link.touch_irq_n, 1'b0);
      run_conv(8'h90, 12'h7FE);
      chk_bit(ref_powered_o, 1'b0);
      $display("test reference_power done");
      end_sim();
   end
endmodule : tb
`default_nettype wire
